// file: include/brp_cfg.svh
// Constants of the branch prediction and resolution block
`ifndef BRP_CFG_SVH
`define BRP_CFG_SVH
`define BRP_PC_W 32
`define BRP_LEVELS 3
`define BRP_TAG_W 2
`define BRP_POS_W 2
`define BRP_HIST_DEPTH 64
`define BRP_HIST_IDX_W 6
`define BRP_HIST_IDX_LSB 2
`define BRP_HIST_RESET 2'h2
`define BRP_STACK_DEPTH 8
`define BRP_STACK_PTR_W 3
`define BRP_INSN_BYTES 32'h0000_0004
`define BRP_TARGET_DELAY 2
`define BRP_GAP_HIT 2'h1
`define BRP_GAP_MISS 2'h2
`endif

// file: include/brp_pkg.sv
// Types shared by the branch prediction and resolution block
`include "brp_cfg.svh"
`default_nettype none
package brp_pkg;
    typedef enum logic [1:0] {BRP_PLAIN, BRP_TO_RETURN, BRP_TO_COUNT} brp_kind_type;
    typedef enum logic {BRP_EXEC_IDLE, BRP_EXEC_SECOND} brp_exec_type;
    typedef enum logic [1:0] {BRP_RF_IDLE, BRP_RF_FETCH1, BRP_RF_FETCH2} brp_refetch_type;
    typedef struct packed {
        logic valid;
        logic cond;
        brp_kind_type kind;
        logic hint_taken;
        logic links;
        logic updates_count;
        logic [`BRP_PC_W-1:0] pc;
        logic [`BRP_PC_W-1:0] target;
        logic condition_ready;
        logic condition_taken;
        logic count_decides;
        logic count_taken;
        logic ra_move_pending;
        logic count_move_pending;
        logic target_cache_hit;
    } brp_branch_type;
    typedef struct packed {
        logic valid;
        logic [`BRP_TAG_W-1:0] tag;
        logic taken;
    } brp_resolve_type;
    typedef struct packed {
        logic valid;
        logic [`BRP_TAG_W-1:0] tag;
        logic pred_taken;
        logic [`BRP_PC_W-1:0] alt_pc;
        logic [`BRP_HIST_IDX_W-1:0] hist_idx;
    } brp_slot_type;
    typedef struct packed {
        logic valid;
        logic [`BRP_PC_W-1:0] pc;
    } brp_redirect_type;
    typedef struct packed {
        logic valid;
        logic [`BRP_TAG_W-1:0] tag;
    } brp_flush_type;
    typedef struct packed {
        logic valid;
        logic [`BRP_PC_W-1:0] value;
    } brp_retire_type;
endpackage
`default_nettype wire

// file: rtl/brp_history_store.sv
// Direction history store: two-bit saturating counters indexed by branch address
`include "brp_cfg.svh"
`default_nettype none
module brp_history_store (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`BRP_HIST_IDX_W-1:0] rd_idx,
    output logic rd_taken,
    input wire logic wr_en,
    input wire logic [`BRP_HIST_IDX_W-1:0] wr_idx,
    input wire logic wr_taken
);
    import brp_pkg::*;

    typedef struct packed {
        logic [`BRP_HIST_DEPTH-1:0][1:0] cnt;
    } brp_hist_state_type;

    brp_hist_state_type s;
    brp_hist_state_type next_s;

    assign rd_taken = s.cnt[rd_idx][1];

    always_comb begin
        next_s = s;
        if (wr_en) begin
            if (wr_taken && s.cnt[wr_idx] != 2'h3) begin
                next_s.cnt[wr_idx] = s.cnt[wr_idx] + 2'h1;
            end else if (!wr_taken && s.cnt[wr_idx] != 2'h0) begin
                next_s.cnt[wr_idx] = s.cnt[wr_idx] - 2'h1;
            end
        end
    end

    // Weakly taken start avoids a cold flush on every first backward loop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= {`BRP_HIST_DEPTH{`BRP_HIST_RESET}};
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// file: rtl/brp_branch_unit.sv
// Branch unit: direction and target prediction, tracking and resolution
`include "brp_cfg.svh"
`default_nettype none
module brp_branch_unit (
    input wire logic clk,
    input wire logic resetn,
    input wire logic history_enable,
    input wire brp_pkg::brp_branch_type br_in,
    output logic br_accept,
    output logic fetch_hold,
    output logic branch_stall,
    input wire brp_pkg::brp_resolve_type resolve,
    input wire brp_pkg::brp_retire_type count_retire,
    output brp_pkg::brp_redirect_type redirect,
    output logic fold,
    output logic target_arrive,
    output logic supply_gap,
    output brp_pkg::brp_flush_type completion_flush,
    output logic completion_alloc,
    output logic wb_hold,
    output logic [`BRP_TAG_W-1:0] oldest_tag,
    output logic [`BRP_POS_W-1:0] outstanding,
    output logic dispatch_hold,
    output logic [`BRP_PC_W-1:0] loop_count
);
    import brp_pkg::*;

    typedef struct packed {
        brp_slot_type [`BRP_LEVELS-1:0] slots;
        logic [`BRP_TAG_W-1:0] next_tag;
        brp_exec_type exec;
        brp_refetch_type refetch;
        brp_redirect_type redirect;
        logic fold;
        brp_flush_type completion_flush;
        logic completion_alloc;
        logic [`BRP_TARGET_DELAY-1:0] arrive_pipe;
        logic [1:0] gap;
        logic [`BRP_STACK_DEPTH-1:0][`BRP_PC_W-1:0] stack;
        logic [`BRP_STACK_PTR_W-1:0] stack_ptr;
        logic [`BRP_PC_W-1:0] loop_count;
    } brp_unit_state_type;

    brp_unit_state_type s;
    brp_unit_state_type next_s;
    logic [1:0] rst_sync;
    logic rst_n;
    logic [`BRP_LEVELS-1:0] res_hit;
    logic [`BRP_POS_W-1:0] hit_pos;
    logic hit_any;
    logic mispredict;
    brp_slot_type hit_slot;
    brp_slot_type [`BRP_LEVELS-1:0] work;
    logic hist_taken;
    logic hist_wr_en;
    logic [`BRP_HIST_IDX_W-1:0] hist_wr_idx;
    logic hist_wr_taken;
    logic [`BRP_HIST_IDX_W-1:0] br_idx;
    logic dir_known;
    logic actual_taken;
    logic pred_taken;
    logic taken;
    logic ra_wait;
    logic stall_count;
    logic stall_ra;
    logic stall_levels;
    logic need_second;
    logic free_level;
    logic go;
    logic [`BRP_PC_W-1:0] seq_pc;
    logic [`BRP_PC_W-1:0] tgt_pc;
    logic [`BRP_STACK_PTR_W-1:0] top_ptr;

    // Release of the asynchronous reset is retimed to the clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Per-level tag match against the resolving branch
    genvar g;
    generate
        for (g = 0; g < `BRP_LEVELS; g++) begin : g_match
            assign res_hit[g] = resolve.valid && s.slots[g].valid &&
                s.slots[g].tag == resolve.tag;
        end
    endgenerate

    assign br_idx = br_in.pc[`BRP_HIST_IDX_LSB +: `BRP_HIST_IDX_W];
    assign seq_pc = br_in.pc + `BRP_INSN_BYTES;
    assign top_ptr = s.stack_ptr - `BRP_STACK_PTR_W'(1);

    brp_history_store u_history (
        .clk(clk),
        .rst_n(rst_n),
        .rd_idx(br_idx),
        .rd_taken(hist_taken),
        .wr_en(hist_wr_en),
        .wr_idx(hist_wr_idx),
        .wr_taken(hist_wr_taken)
    );

    always_comb begin
        hit_pos = `BRP_POS_W'(`BRP_LEVELS);
        for (int i = `BRP_LEVELS - 1; i >= 0; i--) begin
            if (res_hit[i]) begin
                hit_pos = `BRP_POS_W'(i);
            end
        end
        hit_any = |res_hit;
        hit_slot = '0;
        if (hit_any) begin
            hit_slot = s.slots[hit_pos];
        end
        mispredict = hit_any && (hit_slot.pred_taken != resolve.taken);
        work = s.slots;
        for (int i = 0; i < `BRP_LEVELS; i++) begin
            if (hit_any && `BRP_POS_W'(i) >= hit_pos) begin
                if (mispredict) begin
                    work[i] = '0;
                end else if (i < `BRP_LEVELS - 1) begin
                    work[i] = s.slots[i + 1];
                end else begin
                    work[i] = '0;
                end
            end
        end
        free_level = !work[`BRP_LEVELS-1].valid;
    end

    // Direction decision for the branch at the head of the queue
    always_comb begin
        dir_known = !br_in.cond || br_in.count_decides || br_in.condition_ready;
        actual_taken = !br_in.cond ? 1'b1 :
            (br_in.count_decides ? br_in.count_taken : br_in.condition_taken);
        pred_taken = history_enable ? hist_taken : br_in.hint_taken;
        taken = dir_known ? actual_taken : pred_taken;
        ra_wait = br_in.kind == BRP_TO_RETURN && br_in.ra_move_pending;
        tgt_pc = ra_wait ? s.stack[top_ptr] : br_in.target;
        stall_count = br_in.kind == BRP_TO_COUNT && br_in.count_move_pending;
        stall_ra = br_in.cond && ra_wait && !dir_known;
        // Any conditional waits while all levels are taken, even a decidable one
        stall_levels = br_in.cond && !free_level;
        need_second = br_in.cond && br_in.kind == BRP_TO_RETURN &&
            s.exec == BRP_EXEC_IDLE;
        go = br_in.valid && !mispredict && !stall_count && !stall_ra &&
            !stall_levels && !need_second;
    end

    assign br_accept = go;
    assign fetch_hold = br_in.valid && stall_count;
    assign branch_stall = br_in.valid && !go;
    assign redirect = s.redirect;
    assign fold = s.fold;
    assign target_arrive = s.arrive_pipe[`BRP_TARGET_DELAY-1];
    assign supply_gap = s.gap != 2'h0;
    assign completion_flush = s.completion_flush;
    assign completion_alloc = s.completion_alloc;
    assign wb_hold = s.slots[0].valid;
    assign oldest_tag = s.slots[0].tag;
    assign dispatch_hold = s.refetch != BRP_RF_IDLE;
    assign loop_count = s.loop_count;

    always_comb begin
        outstanding = '0;
        for (int i = 0; i < `BRP_LEVELS; i++) begin
            outstanding = outstanding + `BRP_POS_W'(s.slots[i].valid);
        end
    end

    // A resolution wins the single history write port over an immediate decision
    always_comb begin
        hist_wr_en = 1'b0;
        hist_wr_idx = br_idx;
        hist_wr_taken = actual_taken;
        if (hit_any) begin
            hist_wr_en = 1'b1;
            hist_wr_idx = hit_slot.hist_idx;
            hist_wr_taken = resolve.taken;
        end else if (go && br_in.cond && dir_known) begin
            hist_wr_en = 1'b1;
        end
    end

    always_comb begin
        next_s = s;
        next_s.slots = work;
        next_s.redirect = '0;
        next_s.fold = 1'b0;
        next_s.completion_flush = '0;
        next_s.completion_alloc = 1'b0;
        next_s.arrive_pipe = {s.arrive_pipe[`BRP_TARGET_DELAY-2:0], 1'b0};
        if (s.gap != 2'h0) begin
            next_s.gap = s.gap - 2'h1;
        end
        case (s.refetch)
            BRP_RF_FETCH1: next_s.refetch = BRP_RF_FETCH2;
            BRP_RF_FETCH2: next_s.refetch = BRP_RF_IDLE;
            default: next_s.refetch = BRP_RF_IDLE;
        endcase
        case (s.exec)
            BRP_EXEC_IDLE: begin
                if (br_in.valid && need_second && !mispredict && !stall_ra) begin
                    next_s.exec = BRP_EXEC_SECOND;
                end
            end
            BRP_EXEC_SECOND: begin
                if (go || !br_in.valid || mispredict) begin
                    next_s.exec = BRP_EXEC_IDLE;
                end
            end
            default: next_s.exec = BRP_EXEC_IDLE;
        endcase
        if (mispredict) begin
            next_s.redirect = {1'b1, hit_slot.alt_pc};
            next_s.completion_flush = {1'b1, hit_slot.tag};
            next_s.refetch = BRP_RF_FETCH1;
            next_s.gap = '0;
            next_s.arrive_pipe = '0;
        end else if (go) begin
            if (taken) begin
                next_s.redirect = {1'b1, tgt_pc};
                next_s.fold = 1'b1;
                next_s.arrive_pipe[0] = br_in.target_cache_hit;
                next_s.gap = br_in.target_cache_hit ? `BRP_GAP_HIT : `BRP_GAP_MISS;
            end
            if (!dir_known) begin
                for (int i = `BRP_LEVELS - 1; i >= 0; i--) begin
                    if (!work[i].valid && (i == 0 || work[i - 1].valid)) begin
                        next_s.slots[i] = {1'b1, s.next_tag, taken,
                            taken ? seq_pc : tgt_pc, br_idx};
                    end
                end
                next_s.next_tag = s.next_tag + `BRP_TAG_W'(1);
            end
            next_s.completion_alloc = br_in.updates_count || br_in.links;
            if (br_in.kind == BRP_TO_RETURN && !br_in.links) begin
                next_s.stack_ptr = top_ptr;
            end else if (br_in.links) begin
                next_s.stack[s.stack_ptr] = seq_pc;
                next_s.stack_ptr = s.stack_ptr + `BRP_STACK_PTR_W'(1);
            end
        end
        // Retirement arrives only after all older work has completed
        if (count_retire.valid) begin
            next_s.loop_count = count_retire.value;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// file: tb/brp_branch_unit_sva.sv
// Port checker of the branch unit
`include "brp_cfg.svh"
`default_nettype none
module brp_branch_unit_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic history_enable,
    input wire brp_pkg::brp_branch_type br_in,
    input wire logic br_accept,
    input wire logic fetch_hold,
    input wire logic branch_stall,
    input wire brp_pkg::brp_resolve_type resolve,
    input wire brp_pkg::brp_retire_type count_retire,
    input wire brp_pkg::brp_redirect_type redirect,
    input wire logic fold,
    input wire logic target_arrive,
    input wire brp_pkg::brp_flush_type completion_flush,
    input wire logic wb_hold,
    input wire logic [`BRP_POS_W-1:0] outstanding,
    input wire logic dispatch_hold,
    input wire logic [`BRP_PC_W-1:0] loop_count
);
    import brp_pkg::*;
    logic unres;
    logic hit_acc;
    assign unres = br_in.valid && br_in.cond && !br_in.condition_ready &&
        !br_in.count_decides;
    assign hit_acc = br_accept && br_in.valid && br_in.target_cache_hit;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_refetch;
        dispatch_hold ##1 dispatch_hold ##1 !dispatch_hold;
    endsequence
    a_stall_flag: assert property (branch_stall == (br_in.valid && !br_accept))
        else $error("stall flag wrong");
    a_level_cap: assert property (
        outstanding == 2'h3 && br_in.valid && br_in.cond && !resolve.valid |-> !br_accept)
        else $error("fourth conditional branch accepted");
    a_target_time: assert property (target_arrive |-> $past(hit_acc, 2))
        else $error("target arrival not two cycles after hit");
    a_count_wait: assert property (
        br_in.valid && br_in.kind == BRP_TO_COUNT && br_in.count_move_pending
        |-> fetch_hold && !br_accept)
        else $error("count branch not held");
    a_write_hold: assert property (wb_hold == (outstanding != 2'h0))
        else $error("write-back hold wrong");
    a_flush_seq: assert property (
        completion_flush.valid |-> (redirect.valid ##0 s_refetch))
        else $error("flush without redirect and refetch");
    a_fold_redirect: assert property (fold |-> redirect.valid)
        else $error("fold without redirect");
    a_retire_count: assert property (
        count_retire.valid |=> loop_count == $past(count_retire.value))
        else $error("count not updated at retirement");
    a_static_hint: assert property (
        !history_enable && unres && br_accept && br_in.kind == BRP_PLAIN
        |=> fold == $past(br_in.hint_taken))
        else $error("static prediction ignores hint");
    a_count_decides: assert property (
        br_accept && br_in.cond && br_in.count_decides && br_in.kind == BRP_PLAIN
        |=> fold == $past(br_in.count_taken))
        else $error("count condition not used");
    a_ret_first: assert property (
        $rose(br_in.valid) && br_in.cond && br_in.kind == BRP_TO_RETURN |-> !br_accept)
        else $error("conditional return took one cycle");
    a_ret_pending: assert property (
        unres && br_in.kind == BRP_TO_RETURN && br_in.ra_move_pending |-> !br_accept)
        else $error("direction and address both predicted");
endmodule
bind brp_branch_unit brp_branch_unit_sva chk (.clk(clk), .resetn(resetn),
    .history_enable(history_enable), .br_in(br_in), .br_accept(br_accept),
    .fetch_hold(fetch_hold), .branch_stall(branch_stall), .resolve(resolve),
    .count_retire(count_retire), .redirect(redirect), .fold(fold),
    .target_arrive(target_arrive), .completion_flush(completion_flush), .wb_hold(wb_hold),
    .outstanding(outstanding),
    .dispatch_hold(dispatch_hold), .loop_count(loop_count));
`default_nettype wire

// file: tb/brp_fetch_model.sv
// Instruction queue head model: presents one branch and holds it until taken
`default_nettype none
module brp_fetch_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire brp_pkg::brp_branch_type req,
    input wire logic br_accept,
    output brp_pkg::brp_branch_type br_in,
    output logic busy
);
    import brp_pkg::*;
    brp_branch_type last;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            last <= '0;
        end else if (busy && br_accept) begin
            busy <= 1'b0;
        end else if (go) begin
            busy <= 1'b1;
            last <= req;
        end
    end
    // Released fields show inverted data so a stale match cannot pass
    always_comb begin
        br_in = busy ? req : ~last;
        br_in.valid = busy;
    end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the branch unit
`include "brp_cfg.svh"
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %h expected %h", $time, a, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import brp_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic history_enable = 1'b0;
    logic go = 1'b0;
    brp_branch_type req = '0;
    brp_branch_type b;
    brp_branch_type br_in;
    brp_resolve_type resolve = '0;
    brp_retire_type count_retire = '0;
    brp_redirect_type redirect;
    brp_flush_type completion_flush;
    logic br_accept, fetch_hold, branch_stall, fold, target_arrive, supply_gap;
    logic wb_hold, dispatch_hold, busy, completion_alloc;
    logic [1:0] oldest_tag, outstanding, t;
    logic [31:0] loop_count;
    int error_cnt = 0;
    int checks = 0;
    int n;
    brp_branch_unit uut (.clk(clk), .resetn(resetn), .history_enable(history_enable),
        .br_in(br_in), .br_accept(br_accept), .fetch_hold(fetch_hold),
        .branch_stall(branch_stall), .resolve(resolve), .count_retire(count_retire),
        .redirect(redirect), .fold(fold), .target_arrive(target_arrive),
        .supply_gap(supply_gap), .completion_flush(completion_flush),
        .completion_alloc(completion_alloc),
        .wb_hold(wb_hold), .oldest_tag(oldest_tag), .outstanding(outstanding),
        .dispatch_hold(dispatch_hold), .loop_count(loop_count));
    brp_fetch_model fm (.clk(clk), .resetn(resetn), .go(go), .req(req),
        .br_accept(br_accept), .br_in(br_in), .busy(busy));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic brp_branch_type mk(logic c, brp_kind_type k, logic h, logic [31:0] p);
        mk = '0;
        mk.valid = 1'b1;
        mk.cond = c;
        mk.kind = k;
        mk.hint_taken = h;
        mk.pc = p;
        mk.target = p + 32'h0000_0400;
    endfunction
    task automatic start(brp_branch_type x);
        @(negedge clk);
        req = x;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
    endtask
    // Returns in the cycle after the accepting edge; n counts presented cycles plus one
    task automatic wait_acc;
        n = 1;
        while (busy) begin
            @(negedge clk);
            n++;
            if (n > 40) begin
                error_cnt++;
                $display("MISMATCH t=%0t branch never accepted", $time);
                report_and_stop();
            end
        end
    endtask
    task automatic send(brp_branch_type x);
        start(x);
        wait_acc();
    endtask
    task automatic res(logic [1:0] tg, logic tk);
        @(negedge clk);
        resolve = '{1'b1, tg, tk};
        @(negedge clk);
        resolve.valid = 1'b0;
    endtask
    task automatic t_dynamic;
        history_enable = 1'b1;
        send(mk(1'b1, BRP_PLAIN, 1'b0, 32'h0000_0040));
        `CHK(fold, 1'b1)
        res(oldest_tag, 1'b1);
        `CHK(outstanding, 2'h0)
        history_enable = 1'b0;
    endtask
    task automatic t_static_taken;
        b = mk(1'b1, BRP_PLAIN, 1'b1, 32'h0000_0100);
        b.target_cache_hit = 1'b1;
        send(b);
        `CHK(redirect.pc, 32'h0000_0500)
        `CHK(fold, 1'b1)
        `CHK(supply_gap, 1'b1)
        `CHK(wb_hold, 1'b1)
        @(negedge clk);
        `CHK(target_arrive, 1'b1)
        `CHK(supply_gap, 1'b0)
        res(oldest_tag, 1'b1);
        `CHK(outstanding, 2'h0)
        `CHK(redirect.valid, 1'b0)
    endtask
    task automatic t_mispredict;
        send(mk(1'b1, BRP_PLAIN, 1'b0, 32'h0000_0200));
        `CHK(fold, 1'b0)
        t = oldest_tag;
        `CHK(t, 2'h2)
        res(t, 1'b1);
        `CHK(redirect.pc, 32'h0000_0600)
        `CHK(completion_flush.valid, 1'b1)
        `CHK(completion_flush.tag, 2'h2)
        `CHK(dispatch_hold, 1'b1)
        @(negedge clk);
        `CHK(dispatch_hold, 1'b1)
        @(negedge clk);
        `CHK(dispatch_hold, 1'b0)
        `CHK(outstanding, 2'h0)
    endtask
    task automatic t_levels;
        for (int i = 0; i < 3; i++) begin
            send(mk(1'b1, BRP_PLAIN, 1'b0, 32'h0000_0300 + 32'(4 * i)));
        end
        `CHK(outstanding, 2'h3)
        send(mk(1'b0, BRP_PLAIN, 1'b0, 32'h0000_0310));
        `CHK(n, 2)
        `CHK(fold, 1'b1)
        start(mk(1'b1, BRP_PLAIN, 1'b0, 32'h0000_0314));
        repeat (3) @(negedge clk);
        `CHK(branch_stall, 1'b1)
        res(oldest_tag, 1'b0);
        wait_acc();
        `CHK(outstanding, 2'h3)
        repeat (3) res(oldest_tag, 1'b0);
        `CHK(outstanding, 2'h0)
        // A wrong guess on the younger of two keeps the older prediction
        send(mk(1'b1, BRP_PLAIN, 1'b0, 32'h0000_0320));
        send(mk(1'b1, BRP_PLAIN, 1'b0, 32'h0000_0324));
        res(2'h0, 1'b1);
        `CHK(redirect.pc, 32'h0000_0724)
        `CHK(completion_flush.tag, 2'h0)
        `CHK(outstanding, 2'h1)
        `CHK(oldest_tag, 2'h3)
        res(2'h3, 1'b0);
        `CHK(outstanding, 2'h0)
    endtask
    task automatic t_count;
        b = mk(1'b0, BRP_TO_COUNT, 1'b0, 32'h0000_0500);
        b.updates_count = 1'b1;
        b.count_move_pending = 1'b1;
        start(b);
        repeat (3) @(negedge clk);
        `CHK(fetch_hold, 1'b1)
        req.count_move_pending = 1'b0;
        wait_acc();
        `CHK(completion_alloc, 1'b1)
        `CHK(loop_count, 32'h0000_0000)
        `CHK(supply_gap, 1'b1)
        count_retire = '{1'b1, 32'h0000_0010};
        @(negedge clk);
        count_retire.valid = 1'b0;
        `CHK(loop_count, 32'h0000_0010)
        `CHK(supply_gap, 1'b1)
        @(negedge clk);
        `CHK(supply_gap, 1'b0)
        b = mk(1'b1, BRP_PLAIN, 1'b0, 32'h0000_0504);
        b.count_decides = 1'b1;
        b.count_taken = 1'b1;
        send(b);
        `CHK(fold, 1'b1)
        `CHK(outstanding, 2'h0)
    endtask
    task automatic t_return;
        b = mk(1'b0, BRP_PLAIN, 1'b0, 32'h0000_0600);
        b.links = 1'b1;
        send(b);
        b = mk(1'b0, BRP_TO_RETURN, 1'b0, 32'h0000_0A00);
        b.ra_move_pending = 1'b1;
        send(b);
        `CHK(redirect.pc, 32'h0000_0604)
        b = mk(1'b1, BRP_TO_RETURN, 1'b0, 32'h0000_0800);
        b.condition_ready = 1'b1;
        b.condition_taken = 1'b1;
        send(b);
        `CHK(n, 3)
        b.ra_move_pending = 1'b1;
        b.condition_ready = 1'b0;
        start(b);
        repeat (3) @(negedge clk);
        `CHK(branch_stall, 1'b1)
        req.condition_ready = 1'b1;
        wait_acc();
        `CHK(outstanding, 2'h0)
    endtask
    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        t_dynamic();
        t_static_taken();
        t_mispredict();
        t_levels();
        t_count();
        t_return();
        report_and_stop();
    end
endmodule
`default_nettype wire
